/* File: core/ctmr_pkg.sv */
package ctmr_pkg;
   // Register pointer and bank select
   localparam logic [3:0] BANK_NORMAL   = 4'h0;
   localparam logic [3:0] BANK_COUNTER  = 4'hD;
   // Offsets within bank D
   localparam logic [3:0] OFF_CTL_FIRST = 4'h0;
   localparam logic [3:0] OFF_CTL_COMMON = 4'h1;
   localparam logic [3:0] OFF_CTL_LONG  = 4'h2;
   localparam logic [3:0] OFF_RLD_LO    = 4'h4;
   localparam logic [3:0] OFF_RLD_HI    = 4'h5;
   localparam logic [3:0] OFF_HOLD_LO   = 4'h6;
   localparam logic [3:0] OFF_HOLD_HI   = 4'h7;
   localparam logic [3:0] OFF_CAP16_LO  = 4'h8;
   localparam logic [3:0] OFF_CAP16_HI  = 4'h9;
   localparam logic [3:0] OFF_CAP_RISE  = 4'hA;
   localparam logic [3:0] OFF_CAP_FALL  = 4'hB;
   // Field positions
   localparam int BIT_ENABLE     = 7;
   localparam int BIT_SINGLE     = 6;
   localparam int BIT_TIMEOUT    = 5;
   localparam int BIT_PIN_SEL    = 4;
   localparam int BIT_EDGE_IE    = 2;
   localparam int BIT_TOUT_IE    = 1;
   localparam int BIT_MODE       = 7;
   localparam int BIT_OUT_SEL    = 6;
   localparam int BIT_FALL_FLAG  = 0;
   localparam int BIT_RISE_FLAG  = 1;
   // Reset values
   localparam logic [7:0] RST_BYTE  = 8'h00;
   localparam logic [7:0] ALL_ONES8 = 8'hFF;
   localparam logic [15:0] ALL_ONES16 = 16'hFFFF;
   // Combining logic codes
   localparam logic [1:0] LOGIC_AND = 2'h0;
   localparam logic [1:0] LOGIC_OR  = 2'h1;
   localparam logic [1:0] LOGIC_NOR = 2'h2;
   // Edge select codes
   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h2;
   // Transmit submodes
   localparam logic [1:0] SUB_NORMAL = 2'h0;
   localparam logic [1:0] SUB_PONG   = 2'h1;
   localparam logic [1:0] SUB_LOW    = 2'h2;
   // Filter lengths in sample-clock cycles
   localparam logic [4:0] FILT_4  = 5'h04;
   localparam logic [4:0] FILT_8  = 5'h08;
   localparam logic [4:0] FILT_16 = 5'h10;
   // Sample clock divider from MCLK
   localparam logic [3:0] SCLK_DIV = 4'h4;
   typedef enum logic [2:0] {
      DM_IDLE = 3'b001,
      DM_ARM  = 3'b010,
      DM_RUN  = 3'b100
   } demod_state_t;
endpackage

/* File: core/glitch_filter.sv */
`timescale 1ns/1ps
`default_nettype none
module glitch_filter (
   input  wire logic       MCLK,
   input  wire logic       RST,
   input  wire logic       tick,
   input  wire logic [1:0] sel,
   input  wire logic       din,
   output logic            dout
);
   logic [4:0] cnt_q;
   logic       out_q;
   wire  [4:0] need = (sel == 2'h1) ? ctmr_pkg::FILT_4 :
                      (sel == 2'h2) ? ctmr_pkg::FILT_8 : ctmr_pkg::FILT_16;
   wire        bypass = (sel == 2'h0);
   wire        differ = (din != out_q);
   assign dout = bypass ? din : out_q;
   // Level must hold for the whole window before it passes
   always_ff @(posedge MCLK) begin
      if (RST) begin
         cnt_q <= 5'h00;
         out_q <= 1'b0;
      end else if (bypass) begin
         cnt_q <= 5'h00;
         out_q <= din;
      end else if (!differ) begin
         cnt_q <= 5'h00;
      end else if (tick) begin
         if (cnt_q + 5'h01 >= need) begin
            out_q <= din;
            cnt_q <= 5'h00;
         end else begin
            cnt_q <= cnt_q + 5'h01;
         end
      end
   end
endmodule
`default_nettype wire

/* File: core/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
   input  wire logic MCLK,
   input  wire logic RST,
   input  wire logic din,
   output logic      dout
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic out_q;
   assign dout = out_q;
   // Change accepted only when stages two and three agree
   always_ff @(posedge MCLK) begin
      if (RST) begin
         s1_q  <= 1'b0;
         s2_q  <= 1'b0;
         s3_q  <= 1'b0;
         out_q <= 1'b0;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            out_q <= s3_q;
         end
      end
   end
endmodule
`default_nettype wire

/* File: core/dual_counter_demod_timer.sv */
// Overview of operation
// - Counter registers appear in low sixteen addresses only when pointer bank nibble is D.
// - Long capture high byte register, readable and writable.
// - Long capture low byte register, readable and writable.
// - Long hold high and low byte registers, readable and writable.
// - Common control bit 7 selects transmit (0, reset) or demodulation (1).
// - Bit 6 routes combined pin in transmit, picks input pin in demodulation.
// - Transmit bits 5:4 combine outputs as AND, OR, NOR, NAND.
// - Demodulation bits 5:4 select falling, rising or both edges; 11 reserved.
// - Transmit bits 3:2 pick normal, ping-pong, long output low or high.
// - Demodulation bits 3:2 pick no filter, 4, 8 or 16 sample cycles.
// - Bit 0 sets long output start level, or is falling-edge flag cleared by 1.
// - Bit 1 sets short output start level, or is rising-edge flag cleared by 1.
// - Later edges store inverted short count in rising or falling capture.
// - Captured edge sets its flag and requests interrupt when edge enable set.
// - After capture the short counter reloads 00FF (low byte all ones) and keeps counting.
// - Short counter zero in demodulation sets time-out, optional interrupt, continues.
// - In ping-pong hardware alternates the two counters' enable bits.
// - In ping-pong each counter's time-out bit sets at its terminal count.
// - Short time-out interrupt only while counter interrupt mask bit is set.
// - A control bit routes short counter output or port value to its pin.
`timescale 1ns/1ps
`default_nettype none
module dual_counter_demod_timer (
   input  wire logic       MCLK,
   input  wire logic       RST,
   input  wire logic [7:0] REG_POINTER,
   input  wire logic [3:0] REG_ADDR,
   input  wire logic       REG_WR,
   input  wire logic       REG_RD,
   input  wire logic [7:0] REG_WDATA,
   output logic      [7:0] REG_RDATA,
   output logic            REG_HIT,
   input  wire logic       DEMOD_PIN_FIRST,
   input  wire logic       DEMOD_PIN_SECOND,
   input  wire logic       SHORT_PORT_VALUE,
   input  wire logic       COMBINED_PORT_VALUE,
   output logic            SHORT_OUT_PIN,
   output logic            COMBINED_OUT_PIN,
   output logic            EDGE_IRQ,
   output logic            TIMEOUT_IRQ,
   output logic            LONG_TIMEOUT_IRQ
);
   logic [7:0] ctl0_q, ctl1_q, ctl2_q;
   logic [7:0] rld_lo_q, rld_hi_q, hold_lo_q, hold_hi_q;
   logic [7:0] cap16_lo_q, cap16_hi_q, cap_rise_q, cap_fall_q;
   logic [15:0] short_cnt_q, long_cnt_q;
   logic        short_out_q, long_out_q;
   logic        demod_prev_q;
   logic [3:0]  div_q;
   ctmr_pkg::demod_state_t dm_q;

   // Bank D decode
   // bank gating
   wire bank_d = (REG_POINTER[3:0] == ctmr_pkg::BANK_COUNTER);
   assign REG_HIT = bank_d;
   wire wr = REG_WR & bank_d;
   function automatic logic wr_at(input logic w, input logic [3:0] a, input logic [3:0] o);
      wr_at = w && (a == o);
   endfunction
   wire wr_c0 = wr_at(wr, REG_ADDR, ctmr_pkg::OFF_CTL_FIRST);
   wire wr_c1 = wr_at(wr, REG_ADDR, ctmr_pkg::OFF_CTL_COMMON);
   wire wr_c2 = wr_at(wr, REG_ADDR, ctmr_pkg::OFF_CTL_LONG);

   wire       demod   = ctl1_q[ctmr_pkg::BIT_MODE];
   wire [1:0] fn_sel  = ctl1_q[5:4];
   wire [1:0] sub_sel = ctl1_q[3:2];
   wire       pong    = !demod && (sub_sel == ctmr_pkg::SUB_PONG);

   // Sample clock enable
   wire tick = (div_q == ctmr_pkg::SCLK_DIV - 4'h1);

   // Demodulator input path
   logic pin1_s, pin2_s, demod_f;
   pin_sync u_sync1 (.MCLK(MCLK), .RST(RST), .din(DEMOD_PIN_FIRST), .dout(pin1_s));
   pin_sync u_sync2 (.MCLK(MCLK), .RST(RST), .din(DEMOD_PIN_SECOND), .dout(pin2_s));
   wire demod_raw = ctl1_q[ctmr_pkg::BIT_OUT_SEL] ? pin2_s : pin1_s;
   glitch_filter u_filt (
      .MCLK (MCLK),
      .RST  (RST),
      .tick (tick),
      .sel  (sub_sel),
      .din  (demod_raw),
      .dout (demod_f)
   );
   wire rise = demod_f & ~demod_prev_q;
   wire fall = ~demod_f & demod_prev_q;
   wire rise_ok = rise && (fn_sel == ctmr_pkg::EDGE_RISE || fn_sel == ctmr_pkg::EDGE_BOTH);
   wire fall_ok = fall && (fn_sel == ctmr_pkg::EDGE_FALL || fn_sel == ctmr_pkg::EDGE_BOTH);
   wire edge_ok = demod && (rise_ok || fall_ok);
   wire short_en = ctl0_q[ctmr_pkg::BIT_ENABLE];
   wire long_en  = ctl2_q[ctmr_pkg::BIT_ENABLE];
   wire capture  = edge_ok && short_en && (dm_q == ctmr_pkg::DM_RUN);
   wire short_zero = (short_cnt_q == 16'h0000);
   wire long_zero  = (long_cnt_q == 16'h0000);
   wire short_tc = short_en && tick && short_zero && !capture;
   wire long_tc  = long_en && tick && long_zero && !demod;
   wire [16:0] short_reload = {1'b0, rld_hi_q, rld_lo_q};
   wire [15:0] long_reload  = {hold_hi_q, hold_lo_q};

   always_ff @(posedge MCLK) begin
      if (RST) begin
         div_q <= 4'h0;
         demod_prev_q <= 1'b0;
      end else begin
         div_q <= tick ? 4'h0 : div_q + 4'h1;
         demod_prev_q <= demod_f;
      end
   end

   // Demodulation sequencer
   // wait for first edge
   always_ff @(posedge MCLK) begin
      if (RST) begin
         dm_q <= ctmr_pkg::DM_IDLE;
      end else begin
         case (dm_q)
            ctmr_pkg::DM_IDLE: begin
               if (demod && short_en) begin
                  dm_q <= ctmr_pkg::DM_ARM;
               end
            end
            ctmr_pkg::DM_ARM: begin
               if (!(demod && short_en)) begin
                  dm_q <= ctmr_pkg::DM_IDLE;
               end else if (edge_ok) begin
                  dm_q <= ctmr_pkg::DM_RUN;
               end
            end
            ctmr_pkg::DM_RUN: begin
               if (!(demod && short_en)) begin
                  dm_q <= ctmr_pkg::DM_IDLE;
               end
            end
            default: dm_q <= ctmr_pkg::DM_IDLE;
         endcase
      end
   end

   // Short counter
   always_ff @(posedge MCLK) begin
      if (RST) begin
         short_cnt_q <= ctmr_pkg::ALL_ONES16;
      end else if (!short_en) begin
         short_cnt_q <= short_reload[15:0];
      end else if (demod) begin
         if (capture || (dm_q == ctmr_pkg::DM_ARM && edge_ok)) begin
            short_cnt_q <= {8'h00, ctmr_pkg::ALL_ONES8};
         end else if (tick && dm_q == ctmr_pkg::DM_RUN) begin
            short_cnt_q <= short_zero ? {8'h00, ctmr_pkg::ALL_ONES8}
                                      : short_cnt_q - 16'h0001;
         end
      end else if (tick) begin
         short_cnt_q <= short_zero ? short_reload[15:0] : short_cnt_q - 16'h0001;
      end
   end

   // Long counter
   always_ff @(posedge MCLK) begin
      if (RST) begin
         long_cnt_q <= ctmr_pkg::ALL_ONES16;
      end else if (!long_en || demod) begin
         long_cnt_q <= long_reload;
      end else if (tick) begin
         long_cnt_q <= long_zero ? long_reload : long_cnt_q - 16'h0001;
      end
   end

   // Capture registers
   always_ff @(posedge MCLK) begin
      if (RST) begin
         cap_rise_q <= ctmr_pkg::RST_BYTE;
         cap_fall_q <= ctmr_pkg::RST_BYTE;
         cap16_lo_q <= ctmr_pkg::RST_BYTE;
         cap16_hi_q <= ctmr_pkg::RST_BYTE;
      end else begin
         if (capture && rise_ok) begin
            cap_rise_q <= ~short_cnt_q[7:0];
         end else if (wr_at(wr, REG_ADDR, ctmr_pkg::OFF_CAP_RISE)) begin
            cap_rise_q <= REG_WDATA;
         end
         if (capture && fall_ok) begin
            cap_fall_q <= ~short_cnt_q[7:0];
         end else if (wr_at(wr, REG_ADDR, ctmr_pkg::OFF_CAP_FALL)) begin
            cap_fall_q <= REG_WDATA;
         end
         if (wr_at(wr, REG_ADDR, ctmr_pkg::OFF_CAP16_HI)) begin
            cap16_hi_q <= REG_WDATA;
         end
         if (wr_at(wr, REG_ADDR, ctmr_pkg::OFF_CAP16_LO)) begin
            cap16_lo_q <= REG_WDATA;
         end
      end
   end

   // Plain data registers
   always_ff @(posedge MCLK) begin
      if (RST) begin
         rld_lo_q  <= ctmr_pkg::RST_BYTE;
         rld_hi_q  <= ctmr_pkg::RST_BYTE;
         hold_lo_q <= ctmr_pkg::RST_BYTE;
         hold_hi_q <= ctmr_pkg::RST_BYTE;
      end else begin
         if (wr_at(wr, REG_ADDR, ctmr_pkg::OFF_RLD_LO)) begin
            rld_lo_q <= REG_WDATA;
         end
         if (wr_at(wr, REG_ADDR, ctmr_pkg::OFF_RLD_HI)) begin
            rld_hi_q <= REG_WDATA;
         end
         if (wr_at(wr, REG_ADDR, ctmr_pkg::OFF_HOLD_LO)) begin
            hold_lo_q <= REG_WDATA;
         end
         if (wr_at(wr, REG_ADDR, ctmr_pkg::OFF_HOLD_HI)) begin
            hold_hi_q <= REG_WDATA;
         end
      end
   end

   // Control registers; hardware set wins over software write
   wire short_tout_set = short_tc && (demod || pong || short_en);
   always_ff @(posedge MCLK) begin
      if (RST) begin
         ctl0_q <= ctmr_pkg::RST_BYTE;
         ctl2_q <= ctmr_pkg::RST_BYTE;
      end else begin
         ctl0_q <= wr_c0 ? REG_WDATA : ctl0_q;
         ctl2_q <= wr_c2 ? REG_WDATA : ctl2_q;
         if (short_tout_set) begin
            ctl0_q[ctmr_pkg::BIT_TIMEOUT] <= 1'b1;
         end
         if (long_tc) begin
            ctl2_q[ctmr_pkg::BIT_TIMEOUT] <= 1'b1;
         end
         if (pong && short_tc) begin
            ctl0_q[ctmr_pkg::BIT_ENABLE] <= 1'b0;
            ctl2_q[ctmr_pkg::BIT_ENABLE] <= 1'b1;
         end else if (pong && long_tc) begin
            ctl2_q[ctmr_pkg::BIT_ENABLE] <= 1'b0;
            ctl0_q[ctmr_pkg::BIT_ENABLE] <= 1'b1;
         end else if (!pong) begin
            // Single-pass stops at terminal count in transmit only
            if (short_tc && !demod && ctl0_q[ctmr_pkg::BIT_SINGLE]) begin
               ctl0_q[ctmr_pkg::BIT_ENABLE] <= 1'b0;
            end
            if (long_tc && ctl2_q[ctmr_pkg::BIT_SINGLE]) begin
               ctl2_q[ctmr_pkg::BIT_ENABLE] <= 1'b0;
            end
         end
      end
   end

   // Common control: flags in demod are write-one-to-clear
   // mode bit, transmit after reset
   always_ff @(posedge MCLK) begin
      if (RST) begin
         ctl1_q <= ctmr_pkg::RST_BYTE;
      end else begin
         if (wr_c1) begin
            ctl1_q[7:2] <= REG_WDATA[7:2];
            if (!demod) begin
               ctl1_q[1:0] <= REG_WDATA[1:0];
            end
         end
         if (demod) begin
            if (capture && fall_ok) begin
               ctl1_q[ctmr_pkg::BIT_FALL_FLAG] <= 1'b1;
            end else if (wr_c1 && REG_WDATA[ctmr_pkg::BIT_FALL_FLAG]) begin
               ctl1_q[ctmr_pkg::BIT_FALL_FLAG] <= 1'b0;
            end
            if (capture && rise_ok) begin
               ctl1_q[ctmr_pkg::BIT_RISE_FLAG] <= 1'b1;
            end else if (wr_c1 && REG_WDATA[ctmr_pkg::BIT_RISE_FLAG]) begin
               ctl1_q[ctmr_pkg::BIT_RISE_FLAG] <= 1'b0;
            end
         end
      end
   end

   // Waveform outputs
   always_ff @(posedge MCLK) begin
      if (RST) begin
         short_out_q <= 1'b0;
         long_out_q  <= 1'b0;
      end else if (!demod) begin
         if (!short_en) begin
            short_out_q <= ctl1_q[ctmr_pkg::BIT_RISE_FLAG];
         end else if (short_tc) begin
            short_out_q <= ~short_out_q;
         end
         if (sub_sel == ctmr_pkg::SUB_LOW) begin
            long_out_q <= 1'b0;
         end else if (sub_sel == 2'h3) begin
            long_out_q <= 1'b1;
         end else if (!long_en && !short_en) begin
            long_out_q <= ctl1_q[ctmr_pkg::BIT_FALL_FLAG];
         end else if (long_tc) begin
            long_out_q <= ~long_out_q;
         end
      end
   end

   function automatic logic combine(input logic [1:0] f, input logic a, input logic b);
      case (f)
         ctmr_pkg::LOGIC_AND: combine = a & b;
         ctmr_pkg::LOGIC_OR:  combine = a | b;
         ctmr_pkg::LOGIC_NOR: combine = ~(a | b);
         default:             combine = ~(a & b);
      endcase
   endfunction
   wire combined = combine(fn_sel, short_out_q, long_out_q);
   assign COMBINED_OUT_PIN = (!demod && ctl1_q[ctmr_pkg::BIT_OUT_SEL]) ? combined
                                                                       : COMBINED_PORT_VALUE;
   assign SHORT_OUT_PIN = ctl0_q[ctmr_pkg::BIT_PIN_SEL] ? short_out_q : SHORT_PORT_VALUE;

   // Interrupt requests as levels from sticky flags
   // edge interrupt
   assign EDGE_IRQ = demod && ctl0_q[ctmr_pkg::BIT_EDGE_IE] && (ctl1_q[1:0] != 2'b00);
   assign TIMEOUT_IRQ = ctl0_q[ctmr_pkg::BIT_TOUT_IE] && ctl0_q[ctmr_pkg::BIT_TIMEOUT];
   assign LONG_TIMEOUT_IRQ = ctl2_q[ctmr_pkg::BIT_TOUT_IE] && ctl2_q[ctmr_pkg::BIT_TIMEOUT];

   // Read mux
   logic [7:0] rd_d;
   always_comb begin
      case (REG_ADDR)
         ctmr_pkg::OFF_CTL_FIRST:  rd_d = ctl0_q;
         ctmr_pkg::OFF_CTL_COMMON: rd_d = ctl1_q;
         ctmr_pkg::OFF_CTL_LONG:   rd_d = ctl2_q;
         ctmr_pkg::OFF_RLD_LO:     rd_d = rld_lo_q;
         ctmr_pkg::OFF_RLD_HI:     rd_d = rld_hi_q;
         ctmr_pkg::OFF_HOLD_LO:    rd_d = hold_lo_q;
         ctmr_pkg::OFF_HOLD_HI:    rd_d = hold_hi_q;
         ctmr_pkg::OFF_CAP16_LO:   rd_d = cap16_lo_q;
         ctmr_pkg::OFF_CAP16_HI:   rd_d = cap16_hi_q;
         ctmr_pkg::OFF_CAP_RISE:   rd_d = cap_rise_q;
         ctmr_pkg::OFF_CAP_FALL:   rd_d = cap_fall_q;
         default:                  rd_d = ctmr_pkg::RST_BYTE;
      endcase
   end
   // Registered read data so software sees a stable byte
   logic [7:0] rdata_q;
   always_ff @(posedge MCLK) begin
      if (RST) begin
         rdata_q <= ctmr_pkg::RST_BYTE;
      end else if (REG_RD && bank_d) begin
         rdata_q <= rd_d;
      end
   end
   assign REG_RDATA = rdata_q;
endmodule
`default_nettype wire

/* File: test/ctmr_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module ctmr_monitor (
   input wire logic       MCLK,
   input wire logic       RST,
   input wire logic [7:0] REG_POINTER,
   input wire logic [3:0] REG_ADDR,
   input wire logic       REG_WR,
   input wire logic       REG_RD,
   input wire logic [7:0] REG_WDATA,
   input wire logic [7:0] REG_RDATA,
   input wire logic       REG_HIT,
   input wire logic       SHORT_PORT_VALUE,
   input wire logic       COMBINED_PORT_VALUE,
   input wire logic       SHORT_OUT_PIN,
   input wire logic       COMBINED_OUT_PIN,
   input wire logic       EDGE_IRQ,
   input wire logic       TIMEOUT_IRQ
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (RST);
   // Shadow only bits that hardware never touches, so the copy cannot drift
   logic [2:0] first_q;
   logic [1:0] cmn_q;
   wire        wr_ok = REG_WR && REG_HIT;
   always_ff @(posedge MCLK) begin
      if (RST) begin
         first_q <= 3'h0;
         cmn_q   <= 2'h0;
      end else if (wr_ok && REG_ADDR == ctmr_pkg::OFF_CTL_FIRST) begin
         first_q <= {REG_WDATA[4], REG_WDATA[2], REG_WDATA[1]};
      end else if (wr_ok && REG_ADDR == ctmr_pkg::OFF_CTL_COMMON) begin
         cmn_q <= REG_WDATA[7:6];
      end
   end
   bank_decode_a: assert property (REG_HIT == (REG_POINTER[3:0] == ctmr_pkg::BANK_COUNTER))
      else $error("bank decode wrong");
   other_bank_a: assert property (REG_RD && !REG_HIT |=> $stable(REG_RDATA))
      else $error("read outside bank changed data");
   hold_high_rw_a: assert property (wr_ok && REG_ADDR == 4'h7 ##1 REG_RD && REG_HIT && REG_ADDR == 4'h7 |=> REG_RDATA == $past(REG_WDATA, 2))
      else $error("hold high readback wrong");
   cap_high_rw_a: assert property (wr_ok && REG_ADDR == 4'h9 ##1 REG_RD && REG_HIT && REG_ADDR == 4'h9 |=> REG_RDATA == $past(REG_WDATA, 2))
      else $error("capture high readback wrong");
   cap_low_rw_a: assert property (wr_ok && REG_ADDR == 4'h8 ##1 REG_RD && REG_HIT && REG_ADDR == 4'h8 |=> REG_RDATA == $past(REG_WDATA, 2))
      else $error("capture low readback wrong");
   short_pin_port_a: assert property (!first_q[2] |-> SHORT_OUT_PIN == SHORT_PORT_VALUE)
      else $error("short pin not port value");
   comb_pin_port_a: assert property (cmn_q != 2'b01 |-> COMBINED_OUT_PIN == COMBINED_PORT_VALUE)
      else $error("combined pin not port value");
   tout_irq_mask_a: assert property (!first_q[0] |-> !TIMEOUT_IRQ)
      else $error("time-out request while masked");
   edge_irq_gate_a: assert property (!(cmn_q[1] && first_q[1]) |-> !EDGE_IRQ)
      else $error("edge request while not enabled");
endmodule
bind dual_counter_demod_timer ctmr_monitor mon (.MCLK, .RST, .REG_POINTER, .REG_ADDR, .REG_WR,
   .REG_RD, .REG_WDATA, .REG_RDATA, .REG_HIT, .SHORT_PORT_VALUE, .COMBINED_PORT_VALUE,
   .SHORT_OUT_PIN, .COMBINED_OUT_PIN, .EDGE_IRQ, .TIMEOUT_IRQ);
`default_nettype wire

/* File: test/pulse_source.sv */
`timescale 1ns/1ps
`default_nettype none
module pulse_source (
   input  wire logic       MCLK,
   input  wire logic       go,
   input  wire logic [7:0] width,
   output logic            pin
);
   logic [7:0] left_q = 8'h00;
   // Idle low between pulses; a pulse lasts width cycles
   always @(posedge MCLK) begin
      if (go) begin
         left_q <= width;
      end else if (left_q != 8'h00) begin
         left_q <= left_q - 8'h01;
      end
   end
   assign pin = (left_q != 8'h00);
endmodule
`default_nettype wire

/* File: test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic       mclk = 1'b0;
   logic       rst = 1'b1;
   logic [7:0] ptr = 8'h0D;
   logic [3:0] addr = 4'h0;
   logic       wr_s = 1'b0;
   logic       rd_s = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic       sport = 1'b1;
   logic       go = 1'b0;
   logic [7:0] width = 8'h00;
   logic       use2 = 1'b0;
   logic [7:0] rdata, v;
   logic       hit, spin, cpin, eirq, tirq, lirq, src;
   int         failures = 0;
   int         num_checks = 0;
   time        wr_end = 0;
   logic [7:0] cfg [8] = '{8'h00, 8'h42, 8'h52, 8'h62, 8'h72, 8'h43, 8'h4E, 8'h4B};
   logic       exp [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
   dual_counter_demod_timer DUT (.MCLK(mclk), .RST(rst), .REG_POINTER(ptr), .REG_ADDR(addr),
      .REG_WR(wr_s), .REG_RD(rd_s), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_HIT(hit),
      .DEMOD_PIN_FIRST(use2 ? ~src : src), .DEMOD_PIN_SECOND(use2 ? src : ~src),
      .SHORT_PORT_VALUE(sport), .COMBINED_PORT_VALUE(~sport), .SHORT_OUT_PIN(spin),
      .COMBINED_OUT_PIN(cpin), .EDGE_IRQ(eirq), .TIMEOUT_IRQ(tirq), .LONG_TIMEOUT_IRQ(lirq));
   pulse_source src_model (.MCLK(mclk), .go(go), .width(width), .pin(src));
   initial begin
      forever #5 mclk = ~mclk;
   end
   // Back-to-back writes let one edge pass so the strobe never flips twice in a step
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      if (wr_end == $time) begin
         @(negedge mclk);
      end
      addr = a;
      wdata = d;
      wr_s = 1'b1;
      @(negedge mclk);
      wr_s = 1'b0;
      wr_end = $time;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      addr = a;
      rd_s = 1'b1;
      @(negedge mclk);
      rd_s = 1'b0;
      @(negedge mclk);
      d = rdata;
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic fire(input logic [7:0] w);
      width = w;
      go = 1'b1;
      @(negedge mclk);
      go = 1'b0;
   endtask
   task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask
   // Capture counts may slip one sample tick with the tick phase
   task automatic chk_near(input string what, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if ($isunknown(g) || g > e + 1 || g + 1 < e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      #1000000;
      failures++;
      give_verdict();
   end
   initial begin
      repeat (20) @(negedge mclk);
      rst = 1'b0;
      for (int a = 0; a < 12; a++) begin
         rd(a[3:0], v);
         chk("reset value", 8'h00, v);
      end
      for (int a = 4; a < 12; a++) begin
         wr(a[3:0], {a[3:0], ~a[3:0]});
         rd(a[3:0], v);
         chk("register readback", {a[3:0], ~a[3:0]}, v);
      end
      wr(4'h3, 8'h5A);
      rd(4'h3, v);
      chk("unmapped offset", 8'h00, v);
      ptr = 8'h70;
      idle(1);
      chk("bank hit", 8'h00, {7'h0, hit});
      wr(4'h6, 8'h33);
      rd(4'h6, v);
      ptr = 8'h7D;
      rd(4'h6, v);
      chk("normal bank write", 8'h69, v);
      $display("test registers done");
      chk("short pin port", 8'h01, {7'h0, spin});
      sport = 1'b0;
      idle(1);
      chk("short pin port low", 8'h00, {7'h0, spin});
      wr(4'h0, 8'h10);
      wr(4'h1, 8'h02);
      idle(2);
      chk("short pin level one", 8'h01, {7'h0, spin});
      wr(4'h1, 8'h00);
      idle(2);
      chk("short pin level zero", 8'h00, {7'h0, spin});
      for (int i = 0; i < 8; i++) begin
         wr(4'h1, cfg[i]);
         idle(2);
         chk("combined pin", {7'h0, exp[i]}, {7'h0, cpin});
      end
      $display("test transmit done");
      wr(4'h4, 8'hFF);
      wr(4'h5, 8'hFF);
      wr(4'h0, 8'h00);
      wr(4'h1, 8'h90);
      wr(4'h0, 8'h86);
      fire(8'd20);
      idle(199);
      fire(8'd20);
      idle(29);
      rd(4'hA, v);
      chk_near("rise capture", 8'd50, v);
      idle(68);
      fire(8'd20);
      idle(30);
      rd(4'hA, v);
      chk_near("rise capture reload", 8'd25, v);
      chk("edge request", 8'h01, {7'h0, eirq});
      wr(4'h1, 8'h90);
      rd(4'h1, v);
      chk("rise flag kept", 8'h92, v);
      wr(4'h1, 8'h92);
      rd(4'h1, v);
      chk("rise flag cleared", 8'h90, v);
      chk("edge request cleared", 8'h00, {7'h0, eirq});
      wr(4'h0, 8'h00);
      use2 = 1'b1;
      // Let both synchronisers settle so the pin swap cannot arm the counter
      idle(8);
      wr(4'h1, 8'hE0);
      wr(4'h0, 8'h86);
      fire(8'd120);
      idle(150);
      rd(4'hB, v);
      chk_near("fall capture", 8'd30, v);
      rd(4'h1, v);
      chk("fall flag", 8'hE1, v);
      wr(4'h1, 8'hE9);
      fire(8'd8);
      idle(100);
      rd(4'h1, v);
      chk("glitch filtered", 8'hE8, v);
      $display("test demodulation done");
      chk("no time-out yet", 8'h00, {7'h0, tirq});
      idle(1000);
      rd(4'h0, v);
      chk("time-out flag", 8'hA6, v);
      chk("time-out request", 8'h01, {7'h0, tirq});
      wr(4'h0, 8'hA4);
      idle(1);
      chk("time-out masked", 8'h00, {7'h0, tirq});
      wr(4'h2, 8'h02);
      idle(1);
      chk("long request idle", 8'h00, {7'h0, lirq});
      $display("test time-out done");
      wr(4'h0, 8'h00);
      wr(4'h1, 8'h04);
      wr(4'h4, 8'h02);
      wr(4'h5, 8'h00);
      wr(4'h6, 8'h03);
      wr(4'h7, 8'h00);
      wr(4'h2, 8'h42);
      wr(4'h0, 8'h40);
      wr(4'h0, 8'hC0);
      idle(15);
      rd(4'h2, v);
      chk("pong long enabled", 8'hC2, v);
      rd(4'h0, v);
      chk("pong short stopped", 8'h60, v);
      idle(14);
      rd(4'h0, v);
      chk("pong short again", 8'hE0, v);
      rd(4'h2, v);
      chk("pong long stopped", 8'h62, v);
      chk("long request", 8'h01, {7'h0, lirq});
      $display("test ping-pong done");
      give_verdict();
   end
endmodule
`default_nettype wire
